// ---- demod_offset_loop_config.sv ----
// Purpose: APB register bank steering the frequency and clock recovery loops
// Assumes: carrier_sense_i, sync_detect_i, rx_start_i come from logic on clock_i
// Notes:   One wait state on every APB access; outputs are registered
`timescale 1ns/1ps
`default_nettype none
`include "demod_loop_cfg.svh"
module demod_offset_loop_config #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  sys_rst_i,
  // APB slave
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [ADDR_W-1:0]     paddr_i,
  input  wire logic [31:0]           pwdata_i,
  input  wire logic [3:0]            pstrb_i,
  output logic                       pready_o,
  output logic                       pslverr_o,
  output logic [31:0]                prdata_o,
  // Demodulator events
  input  wire logic                  carrier_sense_i,
  input  wire logic                  sync_detect_i,
  input  wire logic                  rx_start_i,
  // Loop controls
  output logic                       loops_freeze_o,
  output logic                       sync_locked_o,
  output logic [3:0]                 freq_gain_o,
  output logic [3:0]                 ki_gain_o,
  output logic [3:0]                 kp_gain_o,
  output demod_loop_pkg::loop_phase_t loop_phase_o,
  output logic [1:0]                 freq_offset_saturation_o,
  output logic [1:0]                 rate_offset_saturation_o
);
  import demod_loop_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  localparam cfg_state_t RESET_STATE = '{
    foc_cfg:    `CFG_FOC_RST,
    bsc_cfg:    `CFG_BSC_RST,
    phase:      ST_PRESYNC,
    pready:     1'b0,
    pslverr:    1'b0,
    prdata:     32'h0000_0000,
    freeze:     1'b0,
    freq_gain:  4'h0,
    ki_gain:    4'h0,
    kp_gain:    4'h0,
    freq_limit: 2'h0,
    rate_limit: 2'h0
  };

  cfg_state_t  st_ff;
  cfg_state_t  nxt_st;
  logic [3:0]  freq_gain_sel;
  logic [3:0]  ki_gain_sel;
  logic [3:0]  kp_gain_sel;
  logic        post_sync;
  logic [5:0]  reg_idx;
  logic        aligned;
  logic        setup_acc;
  logic        write_acc;

  assign post_sync = (st_ff.phase == ST_POSTSYNC);
  assign reg_idx   = paddr_i[7:2];
  assign aligned   = (paddr_i[1:0] == 2'h0) && ((paddr_i >> 8) == '0);

  // ****************************************************************
  // Gain selection
  // ****************************************************************
  gain_select #(.POST_GAIN(`GAIN_HALF)) u_freq_gain (
    .pre_field_i (st_ff.foc_cfg[`FOC_PRE_HI:`FOC_PRE_LO]),
    .post_bit_i  (st_ff.foc_cfg[`FOC_POST_BIT]),
    .post_sync_i (post_sync),
    .gain_o      (freq_gain_sel)
  );

  gain_select #(.POST_GAIN(`GAIN_HALF)) u_ki_gain (
    .pre_field_i (st_ff.bsc_cfg[`BSC_KI_HI:`BSC_KI_LO]),
    .post_bit_i  (st_ff.bsc_cfg[`BSC_POSTI_BIT]),
    .post_sync_i (post_sync),
    .gain_o      (ki_gain_sel)
  );

  gain_select #(.POST_GAIN(`GAIN_ONE)) u_kp_gain (
    .pre_field_i (st_ff.bsc_cfg[`BSC_KP_HI:`BSC_KP_LO]),
    .post_bit_i  (st_ff.bsc_cfg[`BSC_POSTP_BIT]),
    .post_sync_i (post_sync),
    .gain_o      (kp_gain_sel)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_st    = st_ff;
    setup_acc = psel_i && penable_i && !st_ff.pready;
    write_acc = psel_i && penable_i && st_ff.pready && pwrite_i && pstrb_i[0];

    // Bus answer one cycle into the access phase
    nxt_st.pready  = setup_acc;
    nxt_st.pslverr = 1'b0;
    nxt_st.prdata  = 32'h0000_0000;
    if (setup_acc) begin
      if (!aligned) begin
        nxt_st.pslverr = 1'b1;
      end else begin
        case (reg_idx)
          `CFG_FOC_IDX: begin
            nxt_st.prdata = {26'h0, st_ff.foc_cfg};
          end
          `CFG_BSC_IDX: begin
            nxt_st.prdata = {24'h0, st_ff.bsc_cfg};
          end
          `CFG_STAT_IDX: begin
            nxt_st.prdata[`STAT_SYNC_BIT] = post_sync;
            nxt_st.prdata[`STAT_FRZ_BIT]  = st_ff.freeze;
            nxt_st.pslverr = pwrite_i;
          end
          default: begin
            nxt_st.pslverr = 1'b1;
          end
        endcase
      end
    end

    // Write lands on the edge that completes the transfer
    if (write_acc && aligned && !st_ff.pslverr) begin
      if (reg_idx == `CFG_FOC_IDX) begin
        nxt_st.foc_cfg = pwdata_i[5:0];
      end
      if (reg_idx == `CFG_BSC_IDX) begin
        nxt_st.bsc_cfg = pwdata_i[7:0];
      end
    end

    // Reception phase: a new reception wins over a sync in the same cycle
    case (st_ff.phase)
      ST_PRESYNC: begin
        if (!rx_start_i && sync_detect_i) begin
          nxt_st.phase = ST_POSTSYNC; // RULE11
        end
      end
      ST_POSTSYNC: begin
        if (rx_start_i) begin
          nxt_st.phase = ST_PRESYNC; // RULE11
        end
      end
      default: begin
        nxt_st.phase = ST_PRESYNC;
      end
    endcase

    nxt_st.freeze     = st_ff.foc_cfg[`FOC_GATE_BIT] && !carrier_sense_i; // RULE1
    nxt_st.freq_gain  = freq_gain_sel; // RULE2 RULE3
    nxt_st.ki_gain    = ki_gain_sel; // RULE6 RULE8
    nxt_st.kp_gain    = kp_gain_sel; // RULE7 RULE9
    nxt_st.freq_limit = st_ff.foc_cfg[`FOC_LIM_HI:`FOC_LIM_LO]; // RULE4
    nxt_st.rate_limit = st_ff.bsc_cfg[`BSC_LIM_HI:`BSC_LIM_LO]; // RULE10
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st_ff <= RESET_STATE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign pready_o                 = st_ff.pready;
  assign pslverr_o                = st_ff.pslverr;
  assign prdata_o                 = st_ff.prdata;
  assign loops_freeze_o           = st_ff.freeze;
  assign sync_locked_o            = post_sync;
  assign loop_phase_o             = st_ff.phase;
  assign freq_gain_o              = st_ff.freq_gain;
  assign ki_gain_o                = st_ff.ki_gain;
  assign kp_gain_o                = st_ff.kp_gain;
  assign freq_offset_saturation_o = st_ff.freq_limit;
  assign rate_offset_saturation_o = st_ff.rate_limit;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  logic [3:0] pre_freq_exp;
  logic [3:0] pre_ki_exp;
  logic [3:0] pre_kp_exp;
  assign pre_freq_exp = {({1'b0, st_ff.foc_cfg[`FOC_PRE_HI:`FOC_PRE_LO]} + 3'h1), 1'b0};
  assign pre_ki_exp   = {({1'b0, st_ff.bsc_cfg[`BSC_KI_HI:`BSC_KI_LO]} + 3'h1), 1'b0};
  assign pre_kp_exp   = {({1'b0, st_ff.bsc_cfg[`BSC_KP_HI:`BSC_KP_LO]} + 3'h1), 1'b0};

  sequence s_new_rx;
    rx_start_i;
  endsequence

  sequence s_sync_hit;
    !rx_start_i && sync_detect_i && !post_sync;
  endsequence

  sequence s_one_beat_ready;
    pready_o ##1 !pready_o;
  endsequence

  // Sampled reset in the antecedent keeps the release edge from starting a check
  chk_loop_freeze_gate: assert property ( // RULE1
    !sys_rst_i && st_ff.foc_cfg[`FOC_GATE_BIT] && !carrier_sense_i |=> loops_freeze_o)
    else $error("loops not frozen while carrier gate waits");

  chk_loop_release: assert property ( // RULE1
    !sys_rst_i && !(st_ff.foc_cfg[`FOC_GATE_BIT] && !carrier_sense_i) |=> !loops_freeze_o)
    else $error("loops still frozen after carrier sense or gate off");

  chk_freq_pre_gain: assert property ( // RULE2
    !sys_rst_i && !post_sync |=> freq_gain_o == $past(pre_freq_exp))
    else $error("pre-sync frequency gain wrong");

  chk_freq_post_gain: assert property ( // RULE3
    post_sync |=> freq_gain_o == ($past(st_ff.foc_cfg[`FOC_POST_BIT])
                                  ? `GAIN_HALF : $past(pre_freq_exp)))
    else $error("post-sync frequency gain wrong");

  chk_freq_sat_limit: assert property ( // RULE4
    $changed(st_ff.foc_cfg) |=> freq_offset_saturation_o
                                == $past(st_ff.foc_cfg[`FOC_LIM_HI:`FOC_LIM_LO]))
    else $error("frequency offset limit not following its field");

  chk_ki_pre_gain: assert property ( // RULE6
    !sys_rst_i && !post_sync |=> ki_gain_o == $past(pre_ki_exp))
    else $error("pre-sync integral gain wrong");

  chk_kp_pre_gain: assert property ( // RULE7
    !sys_rst_i && !post_sync |=> kp_gain_o == $past(pre_kp_exp))
    else $error("pre-sync proportional gain wrong");

  chk_ki_post_gain: assert property ( // RULE8
    post_sync && st_ff.bsc_cfg[`BSC_POSTI_BIT] |=> ki_gain_o == `GAIN_HALF)
    else $error("post-sync integral gain not halved");

  chk_kp_post_gain: assert property ( // RULE9
    post_sync |=> kp_gain_o == ($past(st_ff.bsc_cfg[`BSC_POSTP_BIT])
                                ? `GAIN_ONE : $past(pre_kp_exp)))
    else $error("post-sync proportional gain wrong");

  chk_rate_sat_limit: assert property ( // RULE10
    ##1 rate_offset_saturation_o == $past(st_ff.bsc_cfg[`BSC_LIM_HI:`BSC_LIM_LO]))
    else $error("rate offset limit not following its field");

  chk_rx_restart_phase: assert property ( // RULE11
    s_new_rx |=> !sync_locked_o ##1 (freq_gain_o == $past(pre_freq_exp)))
    else $error("new reception did not return to pre-sync gains");

  chk_sync_enters_post: assert property ( // RULE11
    s_sync_hit |=> sync_locked_o)
    else $error("sync word did not switch to post-sync gains");

  chk_sync_held_post: assert property ( // RULE11
    post_sync && !rx_start_i |=> sync_locked_o)
    else $error("post-sync phase left without a new reception");

  // ****************************************************************
  // Bus checks
  // ****************************************************************

  chk_apb_one_wait: assert property (
    psel_i && penable_i && !pready_o |=> s_one_beat_ready)
    else $error("APB answer timing broken");

  chk_apb_idle_zero: assert property (
    !pready_o |-> prdata_o == 32'h0000_0000 && !pslverr_o)
    else $error("read data or error shown outside the answer cycle");

  chk_apb_bad_addr: assert property (
    psel_i && penable_i && !pready_o && !aligned |=> pslverr_o)
    else $error("misaligned access not refused");

  chk_status_readonly: assert property (
    psel_i && penable_i && !pready_o && pwrite_i && aligned
    && reg_idx == `CFG_STAT_IDX |=> pslverr_o)
    else $error("write to status register not refused");

  chk_write_lands: assert property (
    psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0] && !pslverr_o
    && reg_idx == `CFG_BSC_IDX |=> st_ff.bsc_cfg == $past(pwdata_i[7:0]))
    else $error("register write did not land");

  chk_strobe_ignored: assert property (
    psel_i && penable_i && pready_o && pwrite_i && !pstrb_i[0]
    |=> $stable(st_ff.foc_cfg) && $stable(st_ff.bsc_cfg))
    else $error("write without byte strobe changed a register");

endmodule
`default_nettype wire

// ---- demod_loop_cfg.svh ----
// Purpose: Constants for the demodulator tracking-loop configuration block
// Assumes: APB byte address = 4 * register index
// Notes:   Gains are coded in half-units of the base gain (K/2 = 1, K = 2)
//
// Operation
// RULE1: With the carrier gate bit set (its reset value) both loops stay frozen until carrier sense.
// RULE2: Before sync the frequency gain is K, 2K, 3K or 4K by a 2-bit field that resets to 10.
// RULE3: After sync the frequency gain is the pre-sync gain when its bit is 0 and K/2 when 1 (reset 1).
// RULE4: The frequency offset saturates at 0, BW/8, BW/4 or BW/2 by a 2-bit field resetting to 10.
// RULE5: Software sets the frequency offset limit to zero when ASK or OOK is used.
// RULE6: Before sync the clock recovery integral gain is Ki to 4Ki by a 2-bit field resetting to 01.
// RULE7: Before sync the clock recovery proportional gain is Kp to 4Kp by a 2-bit field resetting to 10.
// RULE8: After sync the integral gain is the pre-sync one when its bit is 0 and Ki/2 when 1 (reset 1).
// RULE9: After sync the proportional gain is the pre-sync one when its bit is 0 and Kp when 1 (reset 1).
// RULE10: The data rate offset saturates at 0, 3.125, 6.25 or 12.5 percent by a field resetting to 00.
// RULE11: Each new reception returns both loops to pre-sync gains until a sync word is detected.
`ifndef DEMOD_LOOP_CFG_SVH
`define DEMOD_LOOP_CFG_SVH

// ****************************************************************
// Register indices (byte address is index * 4)
// ****************************************************************
`define CFG_FOC_IDX   6'h19
`define CFG_BSC_IDX   6'h1a
`define CFG_STAT_IDX  6'h20

// ****************************************************************
// Reset values
// ****************************************************************
`define CFG_FOC_RST   6'h36
`define CFG_BSC_RST   8'h6c

// ****************************************************************
// Field positions
// ****************************************************************
`define FOC_GATE_BIT  5
`define FOC_PRE_HI    4
`define FOC_PRE_LO    3
`define FOC_POST_BIT  2
`define FOC_LIM_HI    1
`define FOC_LIM_LO    0
`define BSC_KI_HI     7
`define BSC_KI_LO     6
`define BSC_KP_HI     5
`define BSC_KP_LO     4
`define BSC_POSTI_BIT 3
`define BSC_POSTP_BIT 2
`define BSC_LIM_HI    1
`define BSC_LIM_LO    0
`define STAT_SYNC_BIT 0
`define STAT_FRZ_BIT  1

// ****************************************************************
// Gain codes in half-units
// ****************************************************************
`define GAIN_HALF     4'h1
`define GAIN_ONE      4'h2

`endif

// ---- demod_loop_pkg.sv ----
// Purpose: Types for the demodulator tracking-loop configuration block
// Assumes: Constants come from demod_loop_cfg.svh
// Notes:   One packed struct carries all state of the top module
`default_nettype none
package demod_loop_pkg;

  typedef enum logic [1:0] {
    ST_PRESYNC  = 2'b01,
    ST_POSTSYNC = 2'b10
  } loop_phase_t;

  typedef struct packed {
    logic [5:0]  foc_cfg;
    logic [7:0]  bsc_cfg;
    loop_phase_t phase;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        freeze;
    logic [3:0]  freq_gain;
    logic [3:0]  ki_gain;
    logic [3:0]  kp_gain;
    logic [1:0]  freq_limit;
    logic [1:0]  rate_limit;
  } cfg_state_t;

endpackage
`default_nettype wire

// ---- gain_select.sv ----
// Purpose: Picks a loop gain from a pre-sync field and a post-sync bit
// Assumes: Gains in half-units; pre-sync field n selects (n+1) times base
// Notes:   Combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none
`include "demod_loop_cfg.svh"
module gain_select #(
  parameter logic [3:0] POST_GAIN = `GAIN_HALF
) (
  // Settings
  input  wire logic [1:0] pre_field_i,
  input  wire logic       post_bit_i,
  // Loop phase
  input  wire logic       post_sync_i,
  // Result
  output logic [3:0]      gain_o
);

  logic [2:0] mult;

  always_comb begin
    mult = {1'b0, pre_field_i} + 3'h1;
    if (post_sync_i && post_bit_i) begin
      gain_o = POST_GAIN;
    end else begin
      gain_o = {mult, 1'b0};
    end
  end

endmodule
`default_nettype wire

// ---- demod_offset_loop_config_bench.sv ----
// Purpose: Self-checking bench for the tracking-loop configuration bank
// Assumes: One wait state per APB access; loop controls are registered
// Notes:   Gains are compared as half-unit codes
`timescale 1ns/1ps
`default_nettype none
module demod_offset_loop_config_bench;
  import demod_loop_pkg::*;
  logic        clock_i, sys_rst_i, psel_i, penable_i, pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [3:0]  pstrb_i, freq_gain_o, ki_gain_o, kp_gain_o;
  logic        pready_o, pslverr_o, er, carrier_sense_i, sync_detect_i, rx_start_i;
  logic        loops_freeze_o, sync_locked_o;
  loop_phase_t loop_phase_o;
  logic [1:0]  freq_offset_saturation_o, rate_offset_saturation_o;
  int          fail_count = 0;
  int          total_checks = 0;

`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

  demod_offset_loop_config #(.ADDR_W(8)) demod_offset_loop_config_i (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
    .carrier_sense_i(carrier_sense_i), .sync_detect_i(sync_detect_i),
    .rx_start_i(rx_start_i), .loops_freeze_o(loops_freeze_o),
    .sync_locked_o(sync_locked_o), .freq_gain_o(freq_gain_o), .ki_gain_o(ki_gain_o),
    .kp_gain_o(kp_gain_o), .loop_phase_o(loop_phase_o),
    .freq_offset_saturation_o(freq_offset_saturation_o),
    .rate_offset_saturation_o(rate_offset_saturation_o));

  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  // ****************************************************************
  // Bus and helper tasks
  // ****************************************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge clock_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      finish_test();
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
    `CHECK(er, 1'b0)
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0, 4'h0);
    `CHECK(er, xe)
    if (!xe) `CHECK(rd, x)
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic gains(input logic [3:0] f, input logic [3:0] i, input logic [3:0] p);
    `CHECK(freq_gain_o, f)
    `CHECK(ki_gain_o, i)
    `CHECK(kp_gain_o, p)
  endtask

  task automatic pulse_event(input logic sync);
    @(posedge clock_i);
    if (sync) sync_detect_i <= 1'b1;
    else rx_start_i <= 1'b1;
    @(posedge clock_i);
    sync_detect_i <= 1'b0;
    rx_start_i <= 1'b0;
    settle(3);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    settle(3);
    `CHECK(loops_freeze_o, 1'b1)
    gains(4'h6, 4'h4, 4'h6);
    `CHECK(freq_offset_saturation_o, 2'h2)
    `CHECK(rate_offset_saturation_o, 2'h0)
    `CHECK(loop_phase_o, ST_PRESYNC)
    rdchk(8'h64, 32'h36, 1'b0);
    rdchk(8'h68, 32'h6c, 1'b0);
    rdchk(8'h80, 32'h2, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_freeze();
    @(posedge clock_i);
    carrier_sense_i <= 1'b1;
    settle(3);
    `CHECK(loops_freeze_o, 1'b0)
    @(posedge clock_i);
    carrier_sense_i <= 1'b0;
    settle(3);
    `CHECK(loops_freeze_o, 1'b1)
    wr(8'h64, 32'h16);
    settle(3);
    `CHECK(loops_freeze_o, 1'b0)
    wr(8'h64, 32'h36);
    $display("test freeze done");
  endtask

  task automatic t_fields();
    logic [1:0] n;
    for (int k = 0; k < 4; k++) begin
      n = 2'(k);
      wr(8'h64, {24'h0, 2'b00, 1'b1, n, 1'b1, n});
      wr(8'h68, {24'h0, n, n, 2'b11, n});
      settle(3);
      gains(4'(2 * k + 2), 4'(2 * k + 2), 4'(2 * k + 2));
      `CHECK(freq_offset_saturation_o, n)
      `CHECK(rate_offset_saturation_o, n)
    end
    wr(8'h64, 32'h34);
    settle(3);
    `CHECK(freq_offset_saturation_o, 2'h0)
    wr(8'h64, 32'h36);
    wr(8'h68, 32'h6c);
    $display("test fields done");
  endtask

  task automatic t_sync();
    pulse_event(1'b1);
    `CHECK(sync_locked_o, 1'b1)
    `CHECK(loop_phase_o, ST_POSTSYNC)
    gains(4'h1, 4'h1, 4'h2);
    pulse_event(1'b0);
    `CHECK(sync_locked_o, 1'b0)
    gains(4'h6, 4'h4, 4'h6);
    wr(8'h64, 32'h32);
    wr(8'h68, 32'h60);
    pulse_event(1'b1);
    `CHECK(sync_locked_o, 1'b1)
    gains(4'h6, 4'h4, 4'h6);
    pulse_event(1'b0);
    wr(8'h64, 32'h36);
    wr(8'h68, 32'h6c);
    $display("test sync done");
  endtask

  task automatic t_errors();
    rdchk(8'h70, 32'h0, 1'b1);
    rdchk(8'h65, 32'h0, 1'b1);
    apb(1'b1, 8'h80, 32'h3, 4'hf);
    `CHECK(er, 1'b1)
    apb(1'b1, 8'h64, 32'h0, 4'h0);
    `CHECK(er, 1'b0)
    rdchk(8'h64, 32'h36, 1'b0);
    wr(8'h64, 32'hffffffff);
    rdchk(8'h64, 32'h3f, 1'b0);
    wr(8'h64, 32'h36);
    $display("test errors done");
  endtask

  initial begin
    sys_rst_i = 1'b1;
    {psel_i, penable_i, pwrite_i, carrier_sense_i, sync_detect_i, rx_start_i} = '0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    pstrb_i = 4'h0;
    repeat (12) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_freeze();
    t_fields();
    t_sync();
    t_errors();
    finish_test();
  end
endmodule
`default_nettype wire
